// ### shared/afe_prot_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the
  current-protection configuration block.
  Assumes a 200 MHz clock and a 32-bit AHB-Lite register port.
*/
`ifndef AFE_PROT_DEFINES_SVH
`define AFE_PROT_DEFINES_SVH

// Stored parameter image: printed indexes, byte address is four times the index
`define OC_THR_PARAM_INDEX    6'h10
`define OC_DLY_PARAM_INDEX    6'h11
`define SC_CHG_PARAM_INDEX    6'h14
`define SC_DSG_PARAM_INDEX    6'h15
`define OC_THR_PARAM_ADDR     {`OC_THR_PARAM_INDEX, 2'b00}
`define OC_DLY_PARAM_ADDR     {`OC_DLY_PARAM_INDEX, 2'b00}
`define SC_CHG_PARAM_ADDR     {`SC_CHG_PARAM_INDEX, 2'b00}
`define SC_DSG_PARAM_ADDR     {`SC_DSG_PARAM_INDEX, 2'b00}

// Control, status and front-end image registers
`define STATE_CTRL_ADDR       8'h00
`define STATUS_ADDR           8'h04
`define MASK_ADDR             8'h08
`define LIVE_ADDR             8'h0c
`define FE_OC_THR_ADDR        8'h20
`define FE_OC_DLY_ADDR        8'h24
`define FE_SC_DSG_ADDR        8'h28
`define FE_SC_CHG_ADDR        8'h2c

// Parameter and front-end register reset values
`define OC_THR_PARAM_RESET    8'h0f
`define OC_DLY_PARAM_RESET    8'h0f
`define SC_CHG_PARAM_RESET    8'hf7
`define SC_DSG_PARAM_RESET    8'h0f
`define FE_REG_RESET          8'h00

// Control register fields
`define CTRL_RANGE_BIT        0
`define CTRL_DOUBLE_BIT       1
`define CTRL_RELOAD_BIT       2

// Status and mask fields
`define EVT_OVERCURRENT_DISCHARGE_THRESHOLD_PARAM_BIT        0
`define EVT_SC_DSG_BIT        1
`define EVT_SC_CHG_BIT        2
`define EVT_RELOAD_BIT        3
`define EVT_WIDTH             4

// Combined short-circuit register fields
`define SC_DELAY_MSB          7
`define SC_DELAY_LSB          4
`define SC_THR_MSB            2
`define SC_THR_LSB            0

// Thresholds in mV
`define OC_THR_BASE_MV        50
`define OC_THR_STEP_MV        10
`define OC_THR_BASE_FINE_MV   25
`define OC_THR_STEP_FINE_MV   5
`define SC_THR_BASE_MV        100
`define SC_THR_STEP_MV        50
`define SC_THR_BASE_FINE_MV   50
`define SC_THR_STEP_FINE_MV   25
`define SC_CHG_LAST_COARSE    3'h4

// Time base and delays
`define CLOCK_PERIOD_NS       5
`define TICK_PERIOD_NS        1000
`define TICK_CYCLES           (`TICK_PERIOD_NS / `CLOCK_PERIOD_NS)
`define OC_DELAY_BASE_US      1000
`define OC_DELAY_STEP_US      2000
`define SC_DELAY_STEP_US      61

`endif

// ### shared/afe_prot_pkg.sv
/*
  Types of the current-protection configuration block.
  Assumes afe_prot_defines.svh is on the include path.
*/
`include "afe_prot_defines.svh"

package afe_prot_pkg;

  typedef logic signed [15:0] sense_t;
  typedef logic [15:0]        delay_t;
  typedef logic [7:0]         byte_t;

  typedef enum logic [1:0] {
    ST_POWER_ON = 2'b00,
    ST_COPY     = 2'b01,
    ST_RUN      = 2'b10
  } load_state_e;

  typedef struct packed {
    load_state_e                loadState;
    byte_t                      ocThrParam;
    byte_t                      ocDlyParam;
    byte_t                      scChgParam;
    byte_t                      scDsgParam;
    byte_t                      overcurrentThresholdReg;
    byte_t                      overcurrentDelayReg;
    byte_t                      shortDischargeReg;
    byte_t                      shortChargeReg;
    logic                       senseRangeSelect;
    logic                       shortDelayDouble;
    logic [`EVT_WIDTH-1:0]      status;
    logic [`EVT_WIDTH-1:0]      mask;
    logic [31:0]                readData;
    logic                       writePending;
    byte_t                      writeAddr;
    logic [7:0]                 tickCount;
    logic                       tick;
  } main_state_s;

  typedef struct packed {
    delay_t count;
    logic   tripped;
    logic   trip;
  } timer_state_s;

endpackage : afe_prot_pkg

// ### shared/prot_timer_if.sv
/*
  Link between the configuration block and one fault delay timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps

interface prot_timer_if;
  logic                over;
  logic                tick;
  afe_prot_pkg::delay_t limit;
  logic                trip;

  modport owner (output over, output tick, output limit, input trip);
  modport timer (input over, input tick, input limit, output trip);
endinterface : prot_timer_if

// ### design/fault_delay_timer.sv
/*
  Qualifies one protection: trips once the comparison holds for the limit.
  Assumes tick is a one-cycle pulse every microsecond on the same clock.
*/
`timescale 1ns/100ps

module fault_delay_timer (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   reset_n,
  // Comparison, limit and trip
  prot_timer_if.timer port
);
  import afe_prot_pkg::*;

  timer_state_s s;
  timer_state_s next_s;

  // Count ticks while the excursion lasts; any drop restarts the count
  always_comb begin
    next_s      = s;
    next_s.trip = 1'b0;
    if (!port.over) begin
      next_s.count   = '0;
      next_s.tripped = 1'b0;
    end else if (!s.tripped) begin
      if (s.count >= port.limit) begin
        // One event per excursion, so a held fault does not flood status
        next_s.tripped = 1'b1;
        next_s.trip    = 1'b1;
      end else if (port.tick) begin
        next_s.count = s.count + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign port.trip = s.trip;

endmodule : fault_delay_timer

// ### design/afe_current_protection_config.sv
/*
  Current-protection configuration: stored parameter image, front-end
  registers loaded from it at power reset or firmware full reset, threshold
  and delay decoding, three fault timers, sticky status and interrupt.
  Assumes a single AHB-Lite master, a 200 MHz clock and a signed sense
  difference in mV produced by logic on the same clock.
*/
// Summary of operation
// - Copy overcurrent threshold parameter, default 0x0F
// - Parameter changes apply only after reset reload
// - Coarse overcurrent threshold: 50 mV plus 10 mV/code
// - Fine overcurrent threshold: 5 mV steps to 100
// - Copy overcurrent delay into low four bits
// - Overcurrent delay: 1 ms plus 2 ms/code
// - Copy short discharge byte, delay and threshold
// - Short discharge delay: 61 us per code
// - Doubling bit doubles both short-circuit delays
// - Coarse short discharge threshold: 100 mV, 50 steps
// - Fine short discharge threshold: 50 mV, 25 steps
// - Copy short charge byte, default 0xF7
// - Short charge delay: 61 us per code
// - Short charge compares charging direction, range scaled
// - Front-end registers zero until loaded
// - Charge thresholds negative; coarse codes 5-7 unused
`timescale 1ns/100ps
`include "afe_prot_defines.svh"

module afe_current_protection_config (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output      logic                  hreadyout,
  output      logic                  hresp,
  output      logic [31:0]           hrdata,
  // Sense difference, positive in discharge
  input  wire afe_prot_pkg::sense_t  senseDifference,
  // Fault events and interrupt
  output      logic [2:0]            faultEvent,
  output      logic                  irq
);
  import afe_prot_pkg::*;

  main_state_s s;
  main_state_s next_s;

  logic                  addrPhase;
  logic                  addrMapped;
  logic [`EVT_WIDTH-1:0] events;
  logic [`EVT_WIDTH-1:0] readClear;
  logic [2:0]            overNow;
  delay_t                limitNow [3];
  logic [2:0]            tripNow;
  delay_t                ocThreshold;
  delay_t                scDsgThreshold;
  delay_t                scChgThreshold;
  logic                  scChgUsable;
  logic [3:0]            scDsgDelayCode;
  logic [3:0]            scChgDelayCode;
  delay_t                scDsgDelay;
  delay_t                scChgDelay;

  // Register read decode; bits without a field read as zero
  function automatic logic [31:0] read_mux(input logic [7:0] addr,
                                           input main_state_s st);
    logic [31:0] value;
    value = 32'h0000_0000;
    case (addr)
      `STATE_CTRL_ADDR: begin
        value[`CTRL_RANGE_BIT]  = st.senseRangeSelect;
        value[`CTRL_DOUBLE_BIT] = st.shortDelayDouble;
      end
      `STATUS_ADDR:       value[`EVT_WIDTH-1:0] = st.status;
      `MASK_ADDR:         value[`EVT_WIDTH-1:0] = st.mask;
      `LIVE_ADDR:         value[1:0] = st.loadState;
      `OC_THR_PARAM_ADDR: value[7:0] = st.ocThrParam;
      `OC_DLY_PARAM_ADDR: value[7:0] = st.ocDlyParam;
      `SC_CHG_PARAM_ADDR: value[7:0] = st.scChgParam;
      `SC_DSG_PARAM_ADDR: value[7:0] = st.scDsgParam;
      `FE_OC_THR_ADDR:    value[7:0] = st.overcurrentThresholdReg;
      `FE_OC_DLY_ADDR:    value[7:0] = st.overcurrentDelayReg;
      `FE_SC_DSG_ADDR:    value[7:0] = st.shortDischargeReg;
      `FE_SC_CHG_ADDR:    value[7:0] = st.shortChargeReg;
      default:            value = 32'h0000_0000;
    endcase
    return value;
  endfunction : read_mux

  // Bus qualifiers; the slave never stalls and never errors
  assign addrPhase  = hsel & htrans[1] & hready;
  assign addrMapped = (haddr[31:8] == 24'h00_0000);
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = s.readData;

  // Threshold decode in mV from the loaded front-end registers
  always_comb begin
    if (s.senseRangeSelect) begin
      // Fine range follows the table lines that start at 25 mV (overcurrent) and 50 mV (short circuit)
      ocThreshold = 16'(`OC_THR_BASE_FINE_MV
                    + `OC_THR_STEP_FINE_MV * s.overcurrentThresholdReg[3:0]);
      scDsgThreshold = 16'(`SC_THR_BASE_FINE_MV
                       + `SC_THR_STEP_FINE_MV
                       * s.shortDischargeReg[`SC_THR_MSB:`SC_THR_LSB]);
      scChgThreshold = 16'(`SC_THR_BASE_FINE_MV
                       + `SC_THR_STEP_FINE_MV
                       * s.shortChargeReg[`SC_THR_MSB:`SC_THR_LSB]);
      scChgUsable = 1'b1;
    end else begin
      ocThreshold = 16'(`OC_THR_BASE_MV
                    + `OC_THR_STEP_MV * s.overcurrentThresholdReg[3:0]);
      scDsgThreshold = 16'(`SC_THR_BASE_MV
                       + `SC_THR_STEP_MV
                       * s.shortDischargeReg[`SC_THR_MSB:`SC_THR_LSB]);
      scChgThreshold = 16'(`SC_THR_BASE_MV
                       + `SC_THR_STEP_MV
                       * s.shortChargeReg[`SC_THR_MSB:`SC_THR_LSB]);
      // Codes past the last coarse entry have no threshold; never trip
      scChgUsable = (s.shortChargeReg[`SC_THR_MSB:`SC_THR_LSB]
                     <= `SC_CHG_LAST_COARSE);
    end
  end

  // Delay decode in microsecond ticks
  always_comb begin
    scDsgDelayCode = s.shortDischargeReg[`SC_DELAY_MSB:`SC_DELAY_LSB];
    scChgDelayCode = s.shortChargeReg[`SC_DELAY_MSB:`SC_DELAY_LSB];
    scDsgDelay = 16'(`SC_DELAY_STEP_US * scDsgDelayCode);
    scChgDelay = 16'(`SC_DELAY_STEP_US * scChgDelayCode);
    if (s.shortDelayDouble) begin
      scDsgDelay = {scDsgDelay[14:0], 1'b0};
      scChgDelay = {scChgDelay[14:0], 1'b0};
    end
    limitNow[0] = 16'(`OC_DELAY_BASE_US
                  + `OC_DELAY_STEP_US * s.overcurrentDelayReg[3:0]);
    limitNow[1] = scDsgDelay;
    limitNow[2] = scChgDelay;
  end

  // Comparisons; timers stay idle until the front end is loaded
  always_comb begin
    overNow    = 3'b000;
    if (s.loadState == ST_RUN) begin
      overNow[0] = (senseDifference > $signed(ocThreshold));
      overNow[1] = (senseDifference > $signed(scDsgThreshold));
      // Charging drives the difference negative
      overNow[2] = scChgUsable
                   & (senseDifference < -$signed(scChgThreshold));
    end
  end

  // One timer per protection
  prot_timer_if timerBus [3] ();

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_timer
      assign timerBus[ch].over  = overNow[ch];
      assign timerBus[ch].tick  = s.tick;
      assign timerBus[ch].limit = limitNow[ch];
      assign tripNow[ch]        = timerBus[ch].trip;
      fault_delay_timer u_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .port    (timerBus[ch])
      );
    end
  endgenerate

  // Events raised this cycle
  always_comb begin
    events                  = '0;
    events[`EVT_OVERCURRENT_DISCHARGE_THRESHOLD_PARAM_BIT] = tripNow[0];
    events[`EVT_SC_DSG_BIT] = tripNow[1];
    events[`EVT_SC_CHG_BIT] = tripNow[2];
    events[`EVT_RELOAD_BIT] = (s.loadState == ST_COPY);
    readClear = '0;
    if (addrPhase && !hwrite && addrMapped && haddr[7:0] == `STATUS_ADDR) begin
      readClear = '1;
    end
  end

  // Next state of the whole block
  always_comb begin
    next_s = s;

    // Microsecond time base; a first excursion may gain up to one tick
    next_s.tick = 1'b0;
    if (s.tickCount == 8'(`TICK_CYCLES - 1)) begin
      next_s.tickCount = 8'h00;
      next_s.tick      = 1'b1;
    end else begin
      next_s.tickCount = s.tickCount + 8'h01;
    end

    // Address phase: latch writes, fetch read data now for the data phase
    next_s.writePending = addrPhase & hwrite & addrMapped;
    if (addrPhase) begin
      next_s.writeAddr = haddr[7:0];
    end
    if (addrPhase && !hwrite) begin
      next_s.readData = addrMapped ? read_mux(haddr[7:0], s) : 32'h0000_0000;
    end

    // Sticky status; a new event wins over a clearing read
    next_s.status = (s.status & ~readClear) | events;

    // Data phase writes; front-end images are read-only from the bus
    if (s.writePending) begin
      case (s.writeAddr)
        `STATE_CTRL_ADDR: begin
          next_s.senseRangeSelect = hwdata[`CTRL_RANGE_BIT];
          next_s.shortDelayDouble = hwdata[`CTRL_DOUBLE_BIT];
          if (hwdata[`CTRL_RELOAD_BIT]) begin
            next_s.loadState = ST_COPY;
          end
        end
        `MASK_ADDR:         next_s.mask       = hwdata[`EVT_WIDTH-1:0];
        // Stored only; the front end sees it at the next reload
        `OC_THR_PARAM_ADDR: next_s.ocThrParam = hwdata[7:0];
        `OC_DLY_PARAM_ADDR: next_s.ocDlyParam = hwdata[7:0];
        `SC_CHG_PARAM_ADDR: next_s.scChgParam = hwdata[7:0];
        `SC_DSG_PARAM_ADDR: next_s.scDsgParam = hwdata[7:0];
        default: begin
        end
      endcase
    end

    // Load sequence: zero images after power-on, one copy cycle, then run
    case (s.loadState)
      ST_POWER_ON: begin
        next_s.loadState = ST_COPY;
      end
      ST_COPY: begin
        next_s.overcurrentThresholdReg = {4'h0, s.ocThrParam[3:0]};
        next_s.overcurrentDelayReg     = {4'h0, s.ocDlyParam[3:0]};
        next_s.shortDischargeReg       = {s.scDsgParam[7:4], 1'b0,
                                          s.scDsgParam[2:0]};
        next_s.shortChargeReg          = {s.scChgParam[7:4], 1'b0,
                                          s.scChgParam[2:0]};
        if (!(s.writePending && s.writeAddr == `STATE_CTRL_ADDR
              && hwdata[`CTRL_RELOAD_BIT])) begin
          next_s.loadState = ST_RUN;
        end
      end
      ST_RUN: begin
      end
      default: begin
        next_s.loadState = ST_POWER_ON;
      end
    endcase
  end

  // State register; front-end images start at zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s                         <= '0;
      s.loadState               <= ST_POWER_ON;
      s.ocThrParam              <= `OC_THR_PARAM_RESET;
      s.ocDlyParam              <= `OC_DLY_PARAM_RESET;
      s.scChgParam              <= `SC_CHG_PARAM_RESET;
      s.scDsgParam              <= `SC_DSG_PARAM_RESET;
      s.overcurrentThresholdReg <= `FE_REG_RESET;
      s.overcurrentDelayReg     <= `FE_REG_RESET;
      s.shortDischargeReg       <= `FE_REG_RESET;
      s.shortChargeReg          <= `FE_REG_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign faultEvent = tripNow;
  assign irq        = |(s.status & s.mask); // Level, held until status read

endmodule : afe_current_protection_config

// ### test/afe_prot_checker.sv
/*
  Port assertions for the current-protection configuration block.
  Assumes one clock domain and a single AHB-Lite master.
*/
`timescale 1ns/100ps

module afe_prot_checker (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 reset_n,
  // Register bus
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  // Sense and events
  input wire afe_prot_pkg::sense_t senseDifference,
  input wire logic [2:0]           faultEvent,
  input wire logic                 irq
);
  import afe_prot_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic taken;
  logic rdTaken;
  logic wrData;
  assign taken = hsel && htrans[1] && hready;
  assign rdTaken = taken && !hwrite;

  // Marks the data phase of a write, when a register may change
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) wrData <= 1'b0;
    else wrData <= taken && hwrite;
  end

  sequence unmappedRead;
    rdTaken && haddr[31:8] != 24'h0;
  endsequence
  sequence quietStart;
    (faultEvent == 3'h0) [*3];
  endsequence

  a_rdata_holds: assert property (!rdTaken |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (unmappedRead |=> hrdata == 32'h0)
    else $error("unmapped read returned nonzero");
  a_event_single: assert property ((faultEvent & $past(faultEvent)) == 3'h0)
    else $error("fault event longer than one cycle");
  a_ocd_over: assert property (faultEvent[0] |-> $past(senseDifference) > 16'sd25)
    else $error("overcurrent event without excursion");
  a_scd_over: assert property (faultEvent[1] |-> $past(senseDifference) > 16'sd50)
    else $error("short discharge event without excursion");
  a_scc_over: assert property (faultEvent[2] |-> $past(senseDifference) < -16'sd50)
    else $error("short charge event without excursion");
  a_quiet_start: assert property ($rose(reset_n) |-> quietStart)
    else $error("fault event right after reset");
  a_irq_rise: assert property ($rose(irq) |->
    $past(faultEvent != 3'h0) || $past(wrData) || $past(wrData, 2) || $past(wrData, 3))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(taken) || $past(wrData))
    else $error("interrupt fell without access");
endmodule : afe_prot_checker

bind afe_current_protection_config afe_prot_checker chk (
  .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .senseDifference(senseDifference), .faultEvent(faultEvent), .irq(irq));

// ### test/ahb_master_model.sv
/*
  Firmware side: single-word AHB-Lite master driving the register port.
  Assumes hready is the one slave's hreadyout.
*/
`timescale 1ns/100ps

module ahb_master_model (
  // Clock
  input wire logic        clock,
  // Requests
  output     logic        hsel,
  output     logic [31:0] haddr,
  output     logic [1:0]  htrans,
  output     logic        hwrite,
  output     logic [2:0]  hsize,
  output     logic [31:0] hwdata,
  // Answer
  input wire logic        hready,
  input wire logic [31:0] hrdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; no wait count is assumed, the bench watchdog ends a hang
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= w ? wd : ~hwdata;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
    hwdata <= ~hwdata; // Data no longer valid, so do not leave it standing
  endtask : xfer
endmodule : ahb_master_model

// ### test/afe_current_protection_config_tb.sv
/*
  Self-checking bench for the current-protection configuration block.
  Assumes the firmware master model and the bound checker.
*/
`timescale 1ns/100ps
`include "afe_prot_defines.svh"

module afe_current_protection_config_tb;
  import afe_prot_pkg::*;
  logic        clock, reset_n, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, faultEvent;
  sense_t      senseDifference;
  int          error_cnt, compares;
  logic [7:0]  pAddr [4] = '{`OC_THR_PARAM_ADDR, `OC_DLY_PARAM_ADDR,
                             `SC_DSG_PARAM_ADDR, `SC_CHG_PARAM_ADDR};
  logic [7:0]  fAddr [4] = '{`FE_OC_THR_ADDR, `FE_OC_DLY_ADDR,
                             `FE_SC_DSG_ADDR, `FE_SC_CHG_ADDR};

  afe_current_protection_config dut (.clock(clock), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .senseDifference(senseDifference), .faultEvent(faultEvent), .irq(irq));
  ahb_master_model master (.clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    master.xfer({24'h0, a}, 1'b1, d, rd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] rd;
    master.xfer({24'h0, a}, 1'b0, 32'h0, rd);
    check(name, exp, rd);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : rd_chk

  // Reload counts as a firmware full reset; range and double ride along
  task automatic reload(input logic [1:0] ctrl);
    wr(`STATE_CTRL_ADDR, {29'h0, 1'b1, ctrl});
    repeat (4) @(posedge clock);
  endtask : reload

  // Short excursion; with delay code 0 the event must show within six cycles
  task automatic probe(input int v, input int b, input logic exp);
    logic seen;
    @(posedge clock);
    senseDifference <= sense_t'(v);
    seen = 1'b0;
    repeat (6) begin
      @(negedge clock);
      seen |= faultEvent[b];
    end
    check("fault event", {31'h0, exp}, {31'h0, seen});
    @(posedge clock);
    senseDifference <= 16'sd0;
    repeat (3) @(posedge clock);
  endtask : probe

  // Cycles from excursion start to event; tick phase may bring it up to one tick early
  task automatic measure(input int v, input int b, input int mult);
    int n;
    int e;
    e = mult * `SC_DELAY_STEP_US * `TICK_CYCLES;
    @(posedge clock);
    senseDifference <= sense_t'(v);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (faultEvent[b] !== 1'b1 && n < 60000);
    check("fault delay", 32'h1, {31'h0, n >= e - `TICK_CYCLES && n <= e + 4});
    @(posedge clock);
    senseDifference <= 16'sd0;
    repeat (3) @(posedge clock);
  endtask : measure

  task automatic t_reset;
    logic [7:0] pr [4] = '{8'h0f, 8'h0f, 8'h0f, 8'hf7};
    logic [7:0] fr [4] = '{8'h0f, 8'h0f, 8'h07, 8'hf7};
    logic [31:0] rd;
    rd_chk(`FE_OC_THR_ADDR, 32'h0, "unloaded image");
    for (int i = 0; i < 4; i++) begin
      rd_chk(pAddr[i], {24'h0, pr[i]}, "param reset");
      rd_chk(fAddr[i], {24'h0, fr[i]}, "image loaded");
    end
    rd_chk(`STATUS_ADDR, 32'h8, "status");
    rd_chk(`STATUS_ADDR, 32'h0, "status cleared");
    rd_chk(`LIVE_ADDR, 32'h2, "load state");
    wr(`FE_OC_THR_ADDR, 32'haa);
    rd_chk(`FE_OC_THR_ADDR, 32'h0f, "image read only");
    master.xfer(32'h100, 1'b0, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
  endtask : t_reset

  task automatic t_reload;
    logic [7:0] np [4] = '{8'hf3, 8'h05, 8'h1c, 8'h2b};
    logic [7:0] old [4] = '{8'h0f, 8'h0f, 8'h07, 8'hf7};
    logic [7:0] nf [4] = '{8'h03, 8'h05, 8'h14, 8'h23};
    for (int i = 0; i < 4; i++) wr(pAddr[i], {24'h0, np[i]});
    for (int i = 0; i < 4; i++) begin
      rd_chk(pAddr[i], {24'h0, np[i]}, "param stored");
      rd_chk(fAddr[i], {24'h0, old[i]}, "image before reload");
    end
    reload(2'h0);
    for (int i = 0; i < 4; i++) rd_chk(fAddr[i], {24'h0, nf[i]}, "image reloaded");
  endtask : t_reload

  task automatic t_thresholds;
    int t;
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        wr(`SC_DSG_PARAM_ADDR, c);
        wr(`SC_CHG_PARAM_ADDR, c);
        reload(r[1:0]);
        t = r ? 50 + 25 * c : 100 + 50 * c;
        probe(t, 1, 1'b0);
        probe(t + 1, 1, 1'b1);
        if (r == 0 && c > 4) probe(-1000, 2, 1'b0);
        else begin
          probe(-t, 2, 1'b0);
          probe(-t - 1, 2, 1'b1);
        end
      end
    end
  endtask : t_thresholds

  task automatic t_irq;
    rd_chk(`STATUS_ADDR, 32'he, "status sticky");
    wr(`MASK_ADDR, 32'h2);
    probe(226, 1, 1'b1);
    @(negedge clock);
    check("irq raised", 32'h1, {31'h0, irq});
    rd_chk(`STATUS_ADDR, 32'h2, "status event");
    @(negedge clock);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(`MASK_ADDR, 32'h1);
    probe(-226, 2, 1'b1);
    @(negedge clock);
    check("irq masked", 32'h0, {31'h0, irq});
    rd_chk(`STATUS_ADDR, 32'h4, "status masked event");
  endtask : t_irq

  task automatic t_delay;
    logic seen;
    wr(`SC_DSG_PARAM_ADDR, 32'h10);
    wr(`SC_CHG_PARAM_ADDR, 32'h10);
    reload(2'h0);
    @(posedge clock);
    senseDifference <= 16'sd200;
    seen = 1'b0;
    repeat (6000) begin
      @(negedge clock);
      seen |= faultEvent[1];
    end
    check("early fault", 32'h0, {31'h0, seen});
    @(posedge clock);
    senseDifference <= 16'sd0;
    repeat (2) @(posedge clock);
    measure(200, 1, 1);
    wr(`STATE_CTRL_ADDR, 32'h2);
    measure(200, 1, 2);
    measure(-200, 2, 2);
  endtask : t_delay

  task automatic give_verdict;
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    reset_n = 1'b0;
    senseDifference = 16'sd0;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_reload();
    t_thresholds();
    t_irq();
    t_delay();
    give_verdict();
  end

  // Watchdog: the run needs about 70k cycles
  initial begin
    repeat (150000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end
endmodule : afe_current_protection_config_tb
